// ===== core/sptx_defines.svh
// constants for the secondary serial port transmit lane block
`ifndef SPTX_DEFINES_SVH
`define SPTX_DEFINES_SVH
`define SPTX_ADDR_LANE6      8'h23
`define SPTX_ADDR_LANE7      8'h24
`define SPTX_ADDR_LANE8      8'h25
`define SPTX_RST_LANE6       8'h05
`define SPTX_RST_LANE7       8'h06
`define SPTX_RST_LANE8       8'h07
`define SPTX_MASK_LANE67     8'h7F
`define SPTX_MASK_LANE8      8'h3F
`define SPTX_SRC_HI          6
`define SPTX_SRC_LO          5
`define SPTX_SLOT_HI         4
`define SPTX_SLOT_LO         0
`define SPTX_SRC_TRI         2'h0
`define SPTX_SRC_A           2'h1
`define SPTX_SRC_B           2'h2
`define SPTX_HALF_SPLIT      5'h10
`define SPTX_WORD_W          32
`define SPTX_HALF_W          16
`endif

// ===== core/sptx_pkg.sv
// types for the secondary serial port transmit lane block
`default_nettype none
package sptx_pkg;
  typedef struct packed {
    logic [1:0] source;
    logic [4:0] slot;
  } sptx_lane_cfg_type;
  typedef struct packed {
    logic       tdm_mode;
    logic       right_half;
    logic [4:0] slot;
    logic       slot_start;
  } sptx_frame_type;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LANE6 = 3'b010,
    ST_LANE7 = 3'b100
  } sptx_state_type;
endpackage
`default_nettype wire

// ===== core/sptx_slot_match.sv
// slot selector match for one transmit lane
`default_nettype none
`include "sptx_defines.svh"
module sptx_slot_match (
  // configuration
  input  wire logic                       en,
  input  wire sptx_pkg::sptx_lane_cfg_type cfg,
  // frame position
  input  wire sptx_pkg::sptx_frame_type   frame,
  // result
  output logic                            hit
);
  wire logic [4:0] half_slot;
  wire logic       want_right;
  wire logic       match_tdm;
  wire logic       match_half;
  assign half_slot  = cfg.slot - `SPTX_HALF_SPLIT;
  assign want_right = cfg.slot >= `SPTX_HALF_SPLIT;
  assign match_tdm  = frame.slot == cfg.slot;
  assign match_half = (want_right == frame.right_half) &&
                      (frame.slot == (want_right ? half_slot : cfg.slot));
  assign hit = en && (frame.tdm_mode ? match_tdm : match_half);
endmodule
`default_nettype wire

// ===== core/sptx_lanes.sv
// transmit lanes six to eight configuration, slot output for lanes six and seven
`default_nettype none
`include "sptx_defines.svh"
// How it works
// - lane six source: off, loopback two, echo two
// - lane six slot resets five, source off
// - slots 0-15: TDM n or left n
// - slots 16-31: TDM n or right n-16
// - lane seven source: off, battery+temp, echo pair
// - lane seven slot resets six, same coding
// - bit seven reads zero, writes ignored
// - lane seven register at 0x24, reset 0x06
// - lane eight register at 0x25, reset 0x07
module sptx_lanes (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     ce,
  // register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic                     reg_wr,
  input  wire logic [7:0]               reg_wdata,
  output logic [7:0]                    reg_rdata,
  // frame position from serial port clocking
  input  wire sptx_pkg::sptx_frame_type frame,
  // data sources
  input  wire logic [31:0]              loopback_ch2,
  input  wire logic [31:0]              echo_ref_ch2,
  input  wire logic [15:0]              battery_half_word,
  input  wire logic [15:0]              temperature_half_word,
  input  wire logic [15:0]              echo_first_half_word,
  input  wire logic [15:0]              echo_second_half_word,
  // slot word out
  output logic [31:0]                   tx_word,
  output logic                          tx_drive,
  output logic [1:0]                    tx_lane_active
);
  // configuration bytes and their next values
  logic [7:0]                       lane6_q;
  logic [7:0]                       lane7_q;
  logic [7:0]                       lane8_q;
  wire logic [7:0]                  lane6_d;
  wire logic [7:0]                  lane7_d;
  wire logic [7:0]                  lane8_d;
  // slot owner and slot word
  sptx_pkg::sptx_state_type         state_q;
  sptx_pkg::sptx_state_type         state_d;
  logic [31:0]                      word_q;
  logic [31:0]                      word_d;
  logic                             drive_q;
  wire logic                        drive_d;
  // decode
  wire logic                        hit6;
  wire logic                        hit7;
  wire logic                        en6;
  wire logic                        en7;
  wire logic                        sel6;
  wire logic                        sel7;
  wire logic                        sel8;
  wire logic                        wr6;
  wire logic                        wr7;
  wire logic                        wr8;
  wire logic                        own6;
  wire logic                        own7;
  wire sptx_pkg::sptx_lane_cfg_type cfg6;
  wire sptx_pkg::sptx_lane_cfg_type cfg7;
  wire sptx_pkg::sptx_state_type    next_owner;
  wire logic [31:0]                 src6_word;
  wire logic [31:0]                 src7_word;
  wire logic [31:0]                 battery_temp_word;
  wire logic [31:0]                 echo_pair_word;

  function automatic sptx_pkg::sptx_lane_cfg_type unpack_cfg(
    input logic [7:0] r);
    sptx_pkg::sptx_lane_cfg_type c;
    c.source = r[`SPTX_SRC_HI:`SPTX_SRC_LO];
    c.slot   = r[`SPTX_SLOT_HI:`SPTX_SLOT_LO];
    return c;
  endfunction

  function automatic logic src_on(input logic [1:0] s);
    return (s == `SPTX_SRC_A) || (s == `SPTX_SRC_B);
  endfunction

  function automatic logic addr_is(input logic [7:0] ad,
                                   input logic [7:0] target);
    return ad == target;
  endfunction

  function automatic logic [7:0] store_byte(input logic       wr,
                                            input logic [7:0] old,
                                            input logic [7:0] wdata,
                                            input logic [7:0] keep);
    return wr ? (wdata & keep) : old;
  endfunction

  assign cfg6 = unpack_cfg(lane6_q);
  assign cfg7 = unpack_cfg(lane7_q);
  assign en6  = src_on(cfg6.source);
  assign en7  = src_on(cfg7.source);
  assign sel6 = addr_is(reg_addr, `SPTX_ADDR_LANE6);
  assign sel7 = addr_is(reg_addr, `SPTX_ADDR_LANE7);
  assign sel8 = addr_is(reg_addr, `SPTX_ADDR_LANE8);
  assign wr6  = reg_wr && sel6;
  assign wr7  = reg_wr && sel7;
  assign wr8  = reg_wr && sel8;

  // read mux, unmapped reads zero
  assign reg_rdata = sel6 ? lane6_q :
                     sel7 ? lane7_q :
                     sel8 ? lane8_q :
                     8'h00;

  // register next values, reserved bits never stored
  assign lane6_d = store_byte(wr6, lane6_q, reg_wdata,
                              `SPTX_MASK_LANE67);
  assign lane7_d = store_byte(wr7, lane7_q, reg_wdata,
                              `SPTX_MASK_LANE67);
  assign lane8_d = store_byte(wr8, lane8_q, reg_wdata, `SPTX_MASK_LANE8);

  // register file
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lane6_q <= `SPTX_RST_LANE6;
    else if (ce)
      lane6_q <= lane6_d;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lane7_q <= `SPTX_RST_LANE7;
    else if (ce)
      lane7_q <= lane7_d;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lane8_q <= `SPTX_RST_LANE8;
    else if (ce)
      lane8_q <= lane8_d;
  end

  sptx_slot_match u_match6 (
    .en    (en6),
    .cfg   (cfg6),
    .frame (frame),
    .hit   (hit6)
  );

  sptx_slot_match u_match7 (
    .en    (en7),
    .cfg   (cfg7),
    .frame (frame),
    .hit   (hit7)
  );

  // source word selection, first half word in the high half
  assign battery_temp_word = {battery_half_word, temperature_half_word};
  assign echo_pair_word    = {echo_first_half_word, echo_second_half_word};
  assign src6_word = (cfg6.source == `SPTX_SRC_A) ? loopback_ch2 :
                     echo_ref_ch2;
  assign src7_word = (cfg7.source == `SPTX_SRC_A) ? battery_temp_word :
                     echo_pair_word;

  // lane six takes a slot over lane seven on collision
  assign next_owner = hit6 ? sptx_pkg::ST_LANE6 :
                      hit7 ? sptx_pkg::ST_LANE7 :
                      sptx_pkg::ST_IDLE;

  // owner and word are taken at slot start, then stand all slot
  always_comb
  begin
    state_d = state_q;
    word_d  = word_q;
    if (frame.slot_start)
    begin
      state_d = next_owner;
      unique case (next_owner)
        sptx_pkg::ST_IDLE:  word_d = 32'h0000_0000;
        sptx_pkg::ST_LANE6: word_d = src6_word;
        sptx_pkg::ST_LANE7: word_d = src7_word;
      endcase
    end
  end

  assign drive_d = state_d != sptx_pkg::ST_IDLE;

  // slot output registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= sptx_pkg::ST_IDLE;
    else if (ce)
      state_q <= state_d;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      word_q <= 32'h0000_0000;
    else if (ce)
      word_q <= word_d;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      drive_q <= 1'b0;
    else if (ce)
      drive_q <= drive_d;
  end

  assign own6           = state_q == sptx_pkg::ST_LANE6;
  assign own7           = state_q == sptx_pkg::ST_LANE7;
  assign tx_word        = word_q;
  assign tx_drive       = drive_q;
  assign tx_lane_active = {own7, own6};
endmodule
`default_nettype wire

// ===== dv/sptx_lanes_asserts.sv
// port assertions for the transmit lane block
`default_nettype none
module sptx_lanes_asserts (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     nrst,
  input wire logic                     ce,
  // register port
  input wire logic [7:0]               reg_addr,
  input wire logic                     reg_wr,
  input wire logic [7:0]               reg_wdata,
  input wire logic [7:0]               reg_rdata,
  // slot side
  input wire sptx_pkg::sptx_frame_type frame,
  input wire logic [31:0]              tx_word,
  input wire logic                     tx_drive,
  input wire logic [1:0]               tx_lane_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_bit7_zero: assert property (!reg_rdata[7])
    else $error("bit seven set");
  a_lane6_store: assert property (ce && reg_wr && reg_addr == 8'h23
    ##1 reg_addr == 8'h23 |-> reg_rdata == ($past(reg_wdata) & 8'h7F))
    else $error("lane six store");
  a_lane7_store: assert property (ce && reg_wr && reg_addr == 8'h24
    ##1 reg_addr == 8'h24 |-> reg_rdata == ($past(reg_wdata) & 8'h7F))
    else $error("lane seven store");
  a_lane8_store: assert property (ce && reg_wr && reg_addr == 8'h25
    ##1 reg_addr == 8'h25 |-> reg_rdata == ($past(reg_wdata) & 8'h3F))
    else $error("lane eight store");
  a_lane8_top: assert property (reg_addr == 8'h25 |-> !reg_rdata[7:6])
    else $error("lane eight top bits");
  a_slot_hold: assert property (!(ce && frame.slot_start) |=>
    $stable({tx_drive, tx_lane_active})) else $error("slot output moved");
  a_drive_owner: assert property (tx_drive == |tx_lane_active)
    else $error("drive without lane");
  a_one_lane: assert property (tx_lane_active != 2'h3)
    else $error("two lanes");
  a_word_hold: assert property (!(ce && frame.slot_start) |=>
    $stable(tx_word)) else $error("slot word moved");
endmodule
bind sptx_lanes sptx_lanes_asserts u_chk (.clk(clk), .nrst(nrst),
  .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .frame(frame), .tx_drive(tx_drive),
  .tx_lane_active(tx_lane_active), .tx_word(tx_word));
`default_nettype wire

// ===== dv/sptx_host.sv
// host side frame clocking model
`default_nettype none
module sptx_host (
  // clock and mode
  input  wire logic                clk,
  input  wire logic                tdm,
  // frame position
  output var sptx_pkg::sptx_frame_type frame
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cnt_q = 7'h00;
  always @(posedge clk) cnt_q <= #1 cnt_q + 7'h01;
  // four cycles a slot, 32 slots or two halves of 16
  assign frame = {tdm, !tdm && cnt_q[6],
    tdm ? cnt_q[6:2] : {1'b0, cnt_q[5:2]}, cnt_q[1:0] == 2'h0};
endmodule
`default_nettype wire

// ===== dv/sptx_lanes_test.sv
// self-checking bench for the transmit lane block
`default_nettype none
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, x, y); end end
module sptx_lanes_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, tdm = 1, wr = 0, ce = 1, dr;
  logic [7:0] a = 8'h00, d = 8'h00, rd, d6, d7;
  logic [31:0] lb = 0, er = 0, tw;
  logic [15:0] bt = 0, tp = 0, e1 = 0, e2 = 0;
  logic [1:0] act;
  logic [34:0] e;
  integer s = 32'hB1458EAC, checks = 0, n_fail = 0;
  sptx_pkg::sptx_frame_type frame;
  always #2 clk = !clk;
  sptx_host host (.clk(clk), .tdm(tdm), .frame(frame));
  sptx_lanes uut (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(a),
    .reg_wr(wr), .reg_wdata(d), .reg_rdata(rd), .frame(frame),
    .loopback_ch2(lb), .echo_ref_ch2(er), .battery_half_word(bt),
    .temperature_half_word(tp), .echo_first_half_word(e1),
    .echo_second_half_word(e2), .tx_word(tw), .tx_drive(dr),
    .tx_lane_active(act));
  function automatic logic [34:0] ex(sptx_pkg::sptx_frame_type f);
    logic [4:0] p;
    p = f.tdm_mode ? f.slot : {f.right_half, f.slot[3:0]};
    if (p == d6[4:0] && ^d6[6:5])
      return {3'b011, d6[6] ? er : lb};
    if (p == d7[4:0] && ^d7[6:5])
      return {3'b101, d7[6] ? {e1, e2} : {bt, tp}};
    return 35'h0;
  endfunction
  task automatic wt(input logic [7:0] ad, dt);
    @(posedge clk) #1 a = ad;
    d = dt;
    wr = 1;
    @(posedge clk) #1 wr = 0;
    `CHK(rd, dt & (ad == 8'h25 ? 8'h3F : 8'h7F))
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000 n_fail++;
    report_and_stop;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 nrst = 1;
    a = 8'h23;
    #1 `CHK(rd, 8'h05)
    `CHK({act, dr}, 3'h0)
    @(posedge clk) #1 a = 8'h24;
    #1 `CHK(rd, 8'h06)
    @(posedge clk) #1 a = 8'h25;
    #1 `CHK(rd, 8'h07)
    for (int n = 0; n < 40; n++)
    begin
      d6 = (n ? 8'($random(s)) : 8'hA5) & 8'h7F;
      d7 = (n ? 8'($random(s)) : 8'h25) & 8'h7F;
      {lb, er} = {$random(s), $random(s)};
      {bt, tp, e1, e2} = {$random(s), $random(s)};
      tdm = s[3];
      wt(8'h23, d6);
      wt(8'h24, d7);
      wt(8'h25, 8'($random(s)) & 8'h3F);
      do @(posedge clk); while (frame.slot_start !== 1'b1);
      repeat (160)
      begin
        @(posedge clk);
        e = ex(frame);
        #1 if (frame.slot_start === 1'b0 && e[32])
          `CHK(tw, e[31:0])
        if (frame.slot_start === 1'b0)
          `CHK({act, dr}, e[34:32])
      end
    end
    @(posedge clk) #1 ce = 0;
    a = 8'h23;
    d = ~d6 & 8'h7F;
    wr = 1;
    @(posedge clk) #1 wr = 0;
    ce = 1;
    `CHK(rd, d6)
    nrst = 0;
    @(posedge clk) #1 nrst = 1;
    `CHK(rd, 8'h05)
    `CHK({act, dr}, 3'h0)
    report_and_stop;
  end
endmodule
`default_nettype wire
